// ---- hdl/lsse_encoder.sv ----
// Seven-segment symbol encoder with segment data registers and panel driver.
// Operation
// - Accept a symbol code 0 to 22 and make one pattern for a digit.
// - Bits 7..0 light segments d c g b label e f a.
// - Codes 0 to 7 give the decimal digit patterns.
// - Codes 8 to 15 give eight, segments a b d e f g, C, A, L, S, r, E.
// - Codes 16 to 22 give P, d, o, b, n, blank, U.
// - Six digits plus four labels; labels lit through the label bit.
// - Each data register drives at most two frontplanes; with twelve frontplanes the seventh register drives none.
// - Four backplanes give a one-quarter duty multiplexed waveform.
// - Panel is four backplanes by twelve frontplanes.
// - Driver supports exactly four backplanes and up to fourteen frontplanes, two per data register.
// - Base clock divided from the main clock by a configured divider.
module lsse_encoder #(
  parameter int FRONTPLANES = lsse_pkg::NUM_FRONTPLANES
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        WR_STROBE,
  input  wire logic [2:0]  DIGIT_SEL,
  input  wire logic [4:0]  SYMBOL_CODE,
  input  wire logic [3:0]  LABEL_SET,
  input  wire logic        CLEAR_DATA,
  input  wire logic [7:0]  DISPLAY_CLOCK_CONFIG,
  input  wire logic        DISPLAY_ENABLE_BIT,
  output logic      [7:0]  PATTERN,
  output logic             PATTERN_VALID,
  output logic      [3:0]  BACKPLANE,
  output logic      [FRONTPLANES-1:0] FRONTPLANE,
  output logic      [55:0] SEGMENT_DATA
);
  // A symbol code is looked up in a registered table, so its pattern
  // appears one edge after the code is taken.
  // The write strobe and digit select are delayed by that same edge, so
  // that the pattern lands in the digit register that it belongs to.
  // The label bit of each of the first four registers is owned by the label
  // inputs and is never touched by a digit write, so a label survives digit updates.
  // A divider counts main clock cycles up to the configured value and
  // then steps the active common, giving the quarter duty multiplex.
  // For each common, the frontplanes pick one bit from their register,
  // two frontplanes sharing one register, one per nibble.
  // Every port leaves through a flip-flop, so commons and segment lines
  // change together on the same edge and never show a mixed phase.
  // While the display is off, commons and segment lines are held dark.

  // Refuse panel widths that the frontplane mux cannot serve.
  if (FRONTPLANES < 1 ||
      FRONTPLANES > lsse_pkg::MAX_FRONTPLANES) begin : g_bad_width
    $error("FRONTPLANES outside the supported panel range");
  end

  // Two frontplanes per data register bound the usable width.
  if (FRONTPLANES > 2 * lsse_pkg::NUM_DATA_REGS) begin : g_bad_regs
    $error("FRONTPLANES exceeds two per data register");
  end

  // The phase counter and the common decode serve four commons only.
  if (lsse_pkg::NUM_BACKPLANES != 4) begin : g_bad_commons
    $error("Only four backplanes are supported");
  end

  // Digit writes must address existing data registers.
  if (lsse_pkg::NUM_DIGITS > lsse_pkg::NUM_DATA_REGS) begin : g_bad_digits
    $error("More digits than data registers");
  end

  logic [7:0]  pattern_rom;
  logic        wr_d_reg;
  logic [2:0]  sel_d_reg;
  logic [7:0]  data_reg [lsse_pkg::NUM_DATA_REGS];
  logic [lsse_pkg::NUM_DATA_REGS-1:0] digit_wr;
  logic [7:0]  div_cnt_reg;
  logic        base_tick;
  lsse_pkg::lsse_phase_t phase_reg;
  logic [3:0]  common_next;
  logic [FRONTPLANES-1:0] fp_next;

  // Lookup of the symbol code, one cycle of latency.
  lsse_code_rom lsse_code_rom_inst (
    .clk     (MCLK),
    .rst     (RST),
    .code    (SYMBOL_CODE),
    .pattern (pattern_rom)
  );

  // Delay the write and digit select to meet the registered pattern.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wr_d_reg  <= 1'b0;
      sel_d_reg <= 3'h0;
    end else begin
      wr_d_reg  <= WR_STROBE;
      sel_d_reg <= DIGIT_SEL;
    end
  end

  // Present the encoded pattern to the caller.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PATTERN <= lsse_pkg::DATA_RESET;
    end else begin
      PATTERN <= pattern_rom;
    end
  end

  // Mark the one cycle in which the pattern belongs to a write.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PATTERN_VALID <= 1'b0;
    end else begin
      PATTERN_VALID <= wr_d_reg;
    end
  end

  // Decode the delayed select into one write enable per data register.
  // Selects beyond the last digit write nothing, so the spare register
  // keeps whatever the last clear left in it.
  always_comb begin
    digit_wr = '0;
    for (int i = 0; i < lsse_pkg::NUM_DIGITS; i++) begin
      if (wr_d_reg && sel_d_reg == 3'(i)) begin
        digit_wr[i] = 1'b1;
      end
    end
  end

  // Segment data registers; a clear wins over a write in the same cycle,
  // and digit writes keep that register's label bit.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < lsse_pkg::NUM_DATA_REGS; i++) begin
        data_reg[i] <= lsse_pkg::DATA_RESET;
      end
    end else if (CLEAR_DATA) begin
      for (int i = 0; i < lsse_pkg::NUM_DATA_REGS; i++) begin
        data_reg[i] <= lsse_pkg::DATA_RESET;
      end
    end else begin
      for (int i = 0; i < lsse_pkg::NUM_DATA_REGS; i++) begin
        if (digit_wr[i]) begin
          data_reg[i][7:4] <= pattern_rom[7:4];
          data_reg[i][2:0] <= pattern_rom[2:0];
        end
      end
      // Only the first four registers carry a label segment.
      for (int i = 0; i < 4; i++) begin
        data_reg[i][lsse_pkg::SEG_LAB_BIT] <= LABEL_SET[i];
      end
    end
  end

  // Mirror of all data registers for observation.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      SEGMENT_DATA <= '0;
    end else begin
      for (int i = 0; i < lsse_pkg::NUM_DATA_REGS; i++) begin
        SEGMENT_DATA[i*8 +: 8] <= data_reg[i];
      end
    end
  end

  // Base clock tick divided down from the main clock.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      div_cnt_reg <= lsse_pkg::CLKDIV_RESET;
    end else if (!DISPLAY_ENABLE_BIT || base_tick) begin
      div_cnt_reg <= lsse_pkg::CLKDIV_RESET;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  assign base_tick = DISPLAY_ENABLE_BIT &&
                     (div_cnt_reg == DISPLAY_CLOCK_CONFIG);

  // Backplane phase steps through four commons on every base tick.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      phase_reg <= 2'h0;
    end else if (!DISPLAY_ENABLE_BIT) begin
      phase_reg <= 2'h0;
    end else if (base_tick) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Each register feeds up to two frontplanes: low nibble even, high nibble odd.
  always_comb begin
    fp_next = '0;
    for (int f = 0; f < FRONTPLANES; f++) begin
      fp_next[f] = data_reg[f / 2][(f % 2) * 4 + int'(phase_reg)];
    end
  end

  // One-hot common for the current phase.
  // Exactly one backplane is active at a time, a quarter of each frame.
  always_comb begin
    common_next = 4'h1 << phase_reg;
  end

  // Drive the commons, all dark while disabled.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      BACKPLANE <= 4'h0;
    end else if (!DISPLAY_ENABLE_BIT) begin
      BACKPLANE <= 4'h0;
    end else begin
      BACKPLANE <= common_next;
    end
  end

  // Drive the segment lines in step with the commons.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      FRONTPLANE <= '0;
    end else if (!DISPLAY_ENABLE_BIT) begin
      FRONTPLANE <= '0;
    end else begin
      FRONTPLANE <= fp_next;
    end
  end
endmodule

// ---- hdl/lsse_pkg.sv ----
// Package with constants and types for the segment encoder and panel driver.
package lsse_pkg;
  // Segment bit positions within one pattern byte.
  localparam int SEG_D_BIT   = 7;
  localparam int SEG_C_BIT   = 6;
  localparam int SEG_G_BIT   = 5;
  localparam int SEG_B_BIT   = 4;
  localparam int SEG_LAB_BIT = 3;
  localparam int SEG_E_BIT   = 2;
  localparam int SEG_F_BIT   = 1;
  localparam int SEG_A_BIT   = 0;
  // Symbol codes.
  localparam logic [4:0] CODE_MAX   = 5'h16;
  localparam logic [7:0] PAT_BLANK  = 8'h00;
  // Panel geometry.
  localparam int NUM_BACKPLANES    = 4;
  localparam int NUM_FRONTPLANES   = 12;
  localparam int MAX_FRONTPLANES   = 26;
  localparam int NUM_DATA_REGS     = 7;
  localparam int NUM_DIGITS        = 6;
  // Reset values.
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [7:0] CLKDIV_RESET  = 8'h00;
  // Backplane phase type.
  typedef logic [1:0] lsse_phase_t;
endpackage

// ---- hdl/lsse_code_rom.sv ----
// Registered lookup from symbol code to segment pattern.
module lsse_code_rom (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [4:0] code,
  output logic      [7:0] pattern
);
  logic [7:0] pat_next;

  // Translate the code; codes above the table blank the digit.
  always_comb begin
    unique case (code)
      5'h00: pat_next = 8'hd7;
      5'h01: pat_next = 8'h50;
      5'h02: pat_next = 8'hb5;
      5'h03: pat_next = 8'hf1;
      5'h04: pat_next = 8'h72;
      5'h05: pat_next = 8'he3;
      5'h06: pat_next = 8'he7;
      5'h07: pat_next = 8'h51;
      5'h08: pat_next = 8'hf7;
      5'h09: pat_next = 8'hb7;
      5'h0a: pat_next = 8'h87;
      5'h0b: pat_next = 8'h77;
      5'h0c: pat_next = 8'h86;
      5'h0d: pat_next = 8'he3;
      5'h0e: pat_next = 8'h24;
      5'h0f: pat_next = 8'ha7;
      5'h10: pat_next = 8'h37;
      5'h11: pat_next = 8'hf4;
      5'h12: pat_next = 8'he4;
      5'h13: pat_next = 8'he6;
      5'h14: pat_next = 8'h64;
      5'h15: pat_next = lsse_pkg::PAT_BLANK;
      5'h16: pat_next = 8'hd6;
      default: pat_next = lsse_pkg::PAT_BLANK;
    endcase
  end

  // The pattern leaves through a register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pattern <= lsse_pkg::DATA_RESET;
    end else begin
      pattern <= pat_next;
    end
  end
endmodule

// ---- testbench/lsse_chk.sv ----
// Port checker for the segment encoder.
module lsse_chk #(
  parameter int FRONTPLANES = 12
) (
  input wire logic                   MCLK,
  input wire logic                   RST,
  input wire logic                   WR_STROBE,
  input wire logic [4:0]             SYMBOL_CODE,
  input wire logic [7:0]             DISPLAY_CLOCK_CONFIG,
  input wire logic                   DISPLAY_ENABLE_BIT,
  input wire logic [7:0]             PATTERN,
  input wire logic                   PATTERN_VALID,
  input wire logic [3:0]             BACKPLANE,
  input wire logic [FRONTPLANES-1:0] FRONTPLANE,
  input wire logic [55:0]            SEGMENT_DATA
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  logic [FRONTPLANES-1:0] fp_exp;
  int                     ph;
  // Expected frontplanes from the data copy and the active common.
  always_comb begin
    ph = 0;
    for (int i = 0; i < 4; i++)
      if (BACKPLANE[i]) ph = i;
    for (int f = 0; f < FRONTPLANES; f++)
      fp_exp[f] = SEGMENT_DATA[(f/2)*8+(f%2)*4+ph];
  end
  a_valid_after_write:
    assert property (WR_STROBE |-> ##2 PATTERN_VALID) else $error("late");
  a_valid_has_cause:
    assert property (PATTERN_VALID |-> $past(WR_STROBE, 2))
    else $error("stray valid");
  a_blank_high_code:
    assert property (SYMBOL_CODE > 5'h16 |-> ##2 PATTERN == 8'h00)
    else $error("not blank");
  a_common_off_idle:
    assert property (!DISPLAY_ENABLE_BIT [*3] |-> BACKPLANE == 4'h0)
    else $error("common on");
  a_common_one_hot:
    assert property (DISPLAY_ENABLE_BIT [*3] |-> $onehot(BACKPLANE))
    else $error("not one hot");
  a_common_rotates:
    assert property ($changed(BACKPLANE) && $past(BACKPLANE) != 4'h0 &&
      BACKPLANE != 4'h0 |-> BACKPLANE == {$past(BACKPLANE[2:0]),
      $past(BACKPLANE[3])}) else $error("bad step");
  a_fast_base_tick:
    assert property ((DISPLAY_ENABLE_BIT && DISPLAY_CLOCK_CONFIG == 8'h00)
      [*4] |-> $changed(BACKPLANE)) else $error("no tick");
  a_front_map:
    assert property ((DISPLAY_ENABLE_BIT && $stable(SEGMENT_DATA)) [*3]
      |-> FRONTPLANE == fp_exp) else $error("bad front");
  c_write: cover property (WR_STROBE ##2 PATTERN_VALID);
  c_blank: cover property (SYMBOL_CODE > 5'h16);
  c_step: cover property ($changed(BACKPLANE));
endmodule

// ---- testbench/lsse_glass.sv ----
// Panel glass model that reads back the byte on the two lowest frontplanes.
module lsse_glass (
  input wire logic        mclk,
  input wire logic [3:0]  backplane,
  input wire logic [11:0] frontplane,
  output logic     [7:0]  glass_byte
);
  // Each driven common latches its two frontplane segments.
  always_ff @(posedge mclk) begin
    for (int p = 0; p < 4; p++)
      if (backplane[p]) begin
        glass_byte[p] <= frontplane[0];
        glass_byte[p+4] <= frontplane[1];
      end
  end
endmodule

// ---- testbench/lsse_encoder_test.sv ----
// Self-checking bench for the segment encoder.
module lsse_encoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] TAB [23] = '{8'hd7, 8'h50, 8'hb5, 8'hf1, 8'h72,
    8'he3, 8'he7, 8'h51, 8'hf7, 8'hb7, 8'h87, 8'h77, 8'h86, 8'he3, 8'h24,
    8'ha7, 8'h37, 8'hf4, 8'he4, 8'he6, 8'h64, 8'h00, 8'hd6};
  logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, clr = 1'b0, en = 1'b0;
  logic [2:0]  dsel = 3'h0;
  logic [4:0]  code = 5'h00;
  logic [3:0]  lab = 4'h0, bp;
  logic [7:0]  cfg = 8'h00, pat, glass;
  logic        pv;
  logic [11:0] fp;
  logic [55:0] seg;
  logic [7:0]  eq[$];
  int          failures = 0, checks_done = 0;
  lsse_encoder lsse_encoder_inst (.MCLK(mclk), .RST(rst), .WR_STROBE(wr),
    .DIGIT_SEL(dsel), .SYMBOL_CODE(code), .LABEL_SET(lab), .CLEAR_DATA(clr),
    .DISPLAY_CLOCK_CONFIG(cfg), .DISPLAY_ENABLE_BIT(en), .PATTERN(pat),
    .PATTERN_VALID(pv), .BACKPLANE(bp), .FRONTPLANE(fp), .SEGMENT_DATA(seg));
  lsse_glass lsse_glass_inst (.mclk(mclk), .backplane(bp), .frontplane(fp),
    .glass_byte(glass));
  always #12.5 mclk = ~mclk;
  task automatic chk(logic [63:0] seen, logic [63:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("BAD %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Raises one encode request at the next edge and notes its pattern.
  task automatic put(logic [4:0] c, logic [2:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    code <= c;
    dsel <= d;
    eq.push_back(c > 5'h16 ? 8'h00 : TAB[c]);
  endtask
  // Compares each announced pattern with the oldest note.
  always @(posedge mclk) if (pv === 1'b1)
    chk(pat, eq.size() ? eq.pop_front() : 8'hx);
  // Sets up the panel, then runs the scenarios back to back.
  initial begin
    void'($urandom(61372));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    cfg <= 8'h00;
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    en <= 1'b1;
    for (int c = 0; c < 27; c++)
      put(c < 23 ? 5'(c) : 5'($urandom_range(31, 23)),
        3'($urandom_range(5, 0)));
    put(5'h02, 3'h0);
    lab <= 4'h1;
    @(posedge mclk);
    wr <= 1'b0;
    cfg <= 8'($urandom_range(3, 1));
    repeat (60) @(posedge mclk);
    chk(glass, TAB[2] | 8'h08);
    put(5'h08, 3'h1);
    clr <= 1'b1;
    lab <= 4'h0;
    @(posedge mclk);
    wr <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(seg, 56'h0);
    clr <= 1'b0;
    en <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(bp, 4'h0);
    // A second reset in mid-run returns the outputs to rest.
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(pat, 8'h00);
    chk(pv, 1'b0);
    chk(fp, 12'h000);
    rst <= 1'b0;
    // The first write after release lands in its digit register.
    put(5'h03, 3'h2);
    @(posedge mclk);
    wr <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(seg[23:16], TAB[3]);
    chk(eq.size(), 0);
    summarize();
  end
  // Cuts a hang short well past the expected run.
  initial begin
    #50us;
    failures++;
    summarize();
  end
endmodule
bind lsse_encoder lsse_chk #(.FRONTPLANES(FRONTPLANES)) lsse_chk_inst (
  .MCLK(MCLK), .RST(RST), .WR_STROBE(WR_STROBE), .SYMBOL_CODE(SYMBOL_CODE),
  .DISPLAY_CLOCK_CONFIG(DISPLAY_CLOCK_CONFIG), .PATTERN(PATTERN),
  .DISPLAY_ENABLE_BIT(DISPLAY_ENABLE_BIT), .PATTERN_VALID(PATTERN_VALID),
  .BACKPLANE(BACKPLANE), .FRONTPLANE(FRONTPLANE), .SEGMENT_DATA(SEGMENT_DATA));
